// file: rtl/tosc_params.svh
// Constants for the tuning oscillator block: offsets, fields, resets, widths
// Behaviour
// - Control bit 2 enables phase dither
// - Control bit 1 enables amplitude dither
// - Control bit 0 runs 32-bit oscillator
// - Disabled: bypass data, oscillator held idle
// - Tuning word signed, bytes 0x11e..0x121
// - Start phase loaded on start or sync
`ifndef TOSC_PARAMS_SVH
`define TOSC_PARAMS_SVH
`define TOSC_ADDR_W 10
`define TOSC_OFF_CTRL 10'h11d
`define TOSC_OFF_TW0 10'h11e
`define TOSC_OFF_TW1 10'h11f
`define TOSC_OFF_TW2 10'h120
`define TOSC_OFF_TW3 10'h121
`define TOSC_OFF_PH_LO 10'h122
`define TOSC_OFF_PH_HI 10'h123
`define TOSC_BIT_EN 0
`define TOSC_BIT_ADITH 1
`define TOSC_BIT_PDITH 2
`define TOSC_CTRL_MASK 8'h07
`define TOSC_RST_BYTE 8'h00
`define TOSC_LFSR_SEED 16'hace1
`endif

// file: rtl/tosc_pkg.sv
// Types shared by the tuning oscillator block
`default_nettype none
package tosc_pkg;
   typedef enum logic [1:0] {
      TOSC_OFF = 2'b00,
      TOSC_RUN = 2'b01
   } tosc_state_e;
   typedef struct packed {
      logic phase_dither;
      logic amp_dither;
      logic enable;
   } tosc_ctrl_s;
   typedef struct packed {
      logic valid;
      logic signed [15:0] i;
      logic signed [15:0] q;
   } tosc_sample_s;
endpackage
`default_nettype wire

// file: rtl/tosc_dither.sv
// Pseudo-random dither source for the tuning oscillator
`timescale 1ns/1ps
`default_nettype none
`include "tosc_params.svh"
module tosc_dither
   import tosc_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic run,
   output logic [15:0] noise
);
   logic [15:0] lfsr_r;
   logic [15:0] lfsr_nxt;

   // Galois LFSR, stepped only while running to save power
   always_comb
   begin
      lfsr_nxt = lfsr_r;
      if (run)
      begin
         lfsr_nxt = {1'b0, lfsr_r[15:1]} ^ (lfsr_r[0] ? 16'hb400 : 16'h0000);
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         lfsr_r <= `TOSC_LFSR_SEED;
      else
         lfsr_r <= lfsr_nxt;
   end

   assign noise = lfsr_r;
endmodule // tosc_dither
`default_nettype wire

// file: rtl/tosc_core.sv
// Register-programmed tuning oscillator with mixer and bypass
`timescale 1ns/1ps
`default_nettype none
`include "tosc_params.svh"
module tosc_core
   import tosc_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic sample_en,
   input wire logic reg_wr,
   input wire logic [`TOSC_ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic sync_event,
   input wire logic signed [15:0] data_in,
   output logic signed [15:0] i_out,
   output logic signed [15:0] q_out,
   output logic out_valid,
   output logic [31:0] phase_acc
);
   // Register file, oscillator state, output stage and datapath nets
   tosc_ctrl_s ctrl_r, ctrl_nxt;
   logic [31:0] tuning_word_r, tuning_word_nxt;
   logic [15:0] start_phase_word_r, start_phase_word_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   tosc_state_e state_r, state_nxt;
   logic [31:0] acc_r, acc_nxt;
   tosc_sample_s out_r, out_nxt;
   logic [15:0] noise;
   logic [31:0] dith_phase;
   logic [15:0] ph_idx;
   logic signed [15:0] cos_v, sin_v;
   logic signed [15:0] mix_i, mix_q;
   logic osc_run;

   // Quarter-wave-free triangle approximation keeps area small; spurs higher than a ROM
   function automatic logic signed [15:0] tri_wave(input logic [15:0] p);
      logic [15:0] t;
      t = p[14] ? ~{p[13:0], 2'b00} : {p[13:0], 2'b00};
      tri_wave = p[15] ? -$signed({1'b0, t[15:1]}) : $signed({1'b0, t[15:1]});
   endfunction

   function automatic logic signed [15:0] mul_q15(input logic signed [15:0] a,
                                                 input logic signed [15:0] b);
      logic signed [31:0] prod;
      prod = a * b;
      mul_q15 = prod[30:15];
   endfunction

   // Amplitude dither: one noise bit as a signed LSB, zero when off
   function automatic logic signed [15:0] dith_lsb(input logic en_v, input logic nb);
      dith_lsb = en_v ? $signed({15'h0000, nb}) : 16'sh0000;
   endfunction

   // Noise source idles with the oscillator, so a disabled block does not toggle
   assign osc_run = (state_r == TOSC_RUN);
   tosc_dither tosc_dither_inst (
      .clock(clock),
      .rst_n(rst_n),
      .run(osc_run),
      .noise(noise)
   );

   // Register writes and read mux
   always_comb
   begin
      ctrl_nxt = ctrl_r;
      tuning_word_nxt = tuning_word_r;
      start_phase_word_nxt = start_phase_word_r;
      if (reg_wr)
      begin
         unique case (reg_addr)
            `TOSC_OFF_CTRL: ctrl_nxt = tosc_ctrl_s'(reg_wdata[2:0]);
            `TOSC_OFF_TW0: tuning_word_nxt[7:0] = reg_wdata;
            `TOSC_OFF_TW1: tuning_word_nxt[15:8] = reg_wdata;
            `TOSC_OFF_TW2: tuning_word_nxt[23:16] = reg_wdata;
            `TOSC_OFF_TW3: tuning_word_nxt[31:24] = reg_wdata;
            `TOSC_OFF_PH_LO: start_phase_word_nxt[7:0] = reg_wdata;
            `TOSC_OFF_PH_HI: start_phase_word_nxt[15:8] = reg_wdata;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_r <= tosc_ctrl_s'(3'h0);
         tuning_word_r <= 32'h00000000;
         start_phase_word_r <= 16'h0000;
      end
      else
      begin
         ctrl_r <= ctrl_nxt;
         tuning_word_r <= tuning_word_nxt;
         start_phase_word_r <= start_phase_word_nxt;
      end
   end

   // Read data registered, so a read answers one cycle after its address
   always_comb
   begin
      unique case (reg_addr)
         `TOSC_OFF_CTRL: rdata_nxt = {5'h00, ctrl_r}; // Bits 7:3 reserved, read 0
         `TOSC_OFF_TW0: rdata_nxt = tuning_word_r[7:0];
         `TOSC_OFF_TW1: rdata_nxt = tuning_word_r[15:8];
         `TOSC_OFF_TW2: rdata_nxt = tuning_word_r[23:16];
         `TOSC_OFF_TW3: rdata_nxt = tuning_word_r[31:24];
         `TOSC_OFF_PH_LO: rdata_nxt = start_phase_word_r[7:0];
         `TOSC_OFF_PH_HI: rdata_nxt = start_phase_word_r[15:8];
         default: rdata_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         rdata_r <= `TOSC_RST_BYTE;
      else
         rdata_r <= rdata_nxt;
   end

   // Phase accumulator: start or sync loads start phase into the top bits
   always_comb
   begin
      state_nxt = state_r;
      acc_nxt = acc_r;
      unique case (state_r)
         TOSC_OFF:
         begin
            acc_nxt = 32'h00000000;
            if (ctrl_r.enable)
            begin
               state_nxt = TOSC_RUN;
               acc_nxt = {start_phase_word_r, 16'h0000};
            end
         end
         TOSC_RUN:
         begin
            if (!ctrl_r.enable)
            begin
               state_nxt = TOSC_OFF;
               acc_nxt = 32'h00000000;
            end
            else if (sync_event)
            begin
               acc_nxt = {start_phase_word_r, 16'h0000};
            end
            else if (sample_en)
            begin
               acc_nxt = acc_r + tuning_word_r; // wraps mod 2^32
            end
         end
         default:
         begin
            state_nxt = TOSC_OFF;
            acc_nxt = 32'h00000000;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r <= TOSC_OFF;
         acc_r <= 32'h00000000;
      end
      else
      begin
         state_r <= state_nxt;
         acc_r <= acc_nxt;
      end
   end

   // Phase dither perturbs bits below the lookup index
   assign dith_phase = ctrl_r.phase_dither ? acc_r + {16'h0000, noise} : acc_r;
   assign ph_idx = dith_phase[31:16];
   assign cos_v = tri_wave(ph_idx + 16'h4000);
   assign sin_v = tri_wave(ph_idx);

   // Mixed products; the bypass path never sees dither
   assign mix_i = mul_q15(data_in, cos_v) + dith_lsb(ctrl_r.amp_dither, noise[0]);
   assign mix_q = mul_q15(data_in, -sin_v) + dith_lsb(ctrl_r.amp_dither, noise[1]);

   // Mixer, or bypass when disabled; amplitude dither adds an LSB of noise
   always_comb
   begin
      out_nxt = out_r;
      if (sample_en)
      begin
         out_nxt.valid = 1'b1;
         if (state_r != TOSC_RUN)
         begin
            out_nxt.i = data_in;
            out_nxt.q = 16'sh0000;
         end
         else
         begin
            out_nxt.i = mix_i;
            out_nxt.q = mix_q;
         end
      end
      else
      begin
         out_nxt.valid = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         out_r <= '0;
      else
         out_r <= out_nxt;
   end

   assign reg_rdata = rdata_r;
   assign i_out = out_r.i;
   assign q_out = out_r.q;
   assign out_valid = out_r.valid;
   assign phase_acc = acc_r;
endmodule // tosc_core
`default_nettype wire

// file: test/tosc_core_asserts.sv
// Checker for the tuning oscillator core ports
`timescale 1ns/1ps
`default_nettype none
`include "tosc_params.svh"
module tosc_core_asserts (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic sample_en,
   input wire logic reg_wr,
   input wire logic [`TOSC_ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic sync_event,
   input wire logic signed [15:0] data_in,
   input wire logic signed [15:0] i_out,
   input wire logic signed [15:0] q_out,
   input wire logic out_valid,
   input wire logic [31:0] phase_acc
);
   logic [6:0][7:0] m_r;
   wire logic [9:0] ix = reg_addr - `TOSC_OFF_CTRL;
   wire logic en = m_r[0][0];
   wire logic [31:0] tw = m_r[4:1];
   wire logic [15:0] ph = m_r[6:5];
   // Shadow of the register map, no shadowing delay
   always_ff @(posedge clock or negedge rst_n)
      if (!rst_n)
         m_r <= '0;
      else if (reg_wr && ix < 10'h7)
         m_r[ix[2:0]] <= reg_wdata;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   a_valid_follows: assert property (sample_en |=> out_valid)
      else $error("out_valid missing");
   a_valid_cause: assert property (out_valid |-> $past(sample_en))
      else $error("out_valid without sample");
   a_bypass_data: assert property (!en && !$past(en) && sample_en |=>
      i_out == $past(data_in) && q_out == 16'h0) else $error("bypass wrong");
   a_off_idle: assert property (!en && !$past(en) |-> phase_acc == 32'h0)
      else $error("acc not idle");
   a_start_load: assert property ($rose(en) |=> phase_acc == {$past(ph), 16'h0})
      else $error("start phase not loaded");
   a_sync_load: assert property (en && $past(en, 2) && sync_event && !reg_wr |=>
      phase_acc == {ph, 16'h0}) else $error("sync reload wrong");
   // Phase dither never reaches the accumulator; its exact step is checked with phase dither off only
   a_acc_add: assert property (en && $past(en) && sample_en && !sync_event
      && !reg_wr && !m_r[0][2] |=> phase_acc == $past(phase_acc) + $past(tw))
      else $error("acc add wrong");
   a_ctrl_read: assert property (ix == 10'h0 && !reg_wr |=>
      reg_rdata == ($past(m_r[0]) & 8'h07)) else $error("ctrl readback");
   a_no_amp_dith: assert property (en && $past(en) && sample_en && data_in == 16'h0
      && !m_r[0][1] |=> i_out == 16'h0 && q_out == 16'h0) else $error("dither while off");
endmodule // tosc_core_asserts
bind tosc_core tosc_core_asserts tosc_core_asserts_inst (.clock, .rst_n, .sample_en,
   .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .sync_event, .data_in, .i_out, .q_out,
   .out_valid, .phase_acc);
`default_nettype wire

// file: test/tosc_core_tb_top.sv
// Self-checking bench for the tuning oscillator core
`timescale 1ns/1ps
`default_nettype none
`include "tosc_params.svh"
module tosc_core_tb_top;
   logic clock = 0, rst_n = 0, sample_en = 0, reg_wr = 0, sync_event = 0;
   logic [`TOSC_ADDR_W-1:0] reg_addr = '0;
   logic [7:0] reg_wdata = '0;
   logic signed [15:0] data_in = '0;
   wire logic [7:0] reg_rdata;
   wire logic signed [15:0] i_out, q_out;
   wire logic out_valid;
   wire logic [31:0] phase_acc;
   int n_fail = 0, compares = 0, cyc = 0;
   // 10 MHz clock
   always #50 clock = ~clock;
   tosc_core tosc_core_inst (.clock, .rst_n, .sample_en, .reg_wr, .reg_addr, .reg_wdata,
      .reg_rdata, .sync_event, .data_in, .i_out, .q_out, .out_valid, .phase_acc);
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         n_fail++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   // Idle cycle after each write keeps strobe edges apart
   task automatic wr(logic [9:0] a, logic [7:0] d);
      reg_wr = 1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clock);
      reg_wr = 0;
      @(negedge clock);
   endtask
   task automatic rd(logic [9:0] a, logic [7:0] e, string nm);
      reg_addr = a;
      @(negedge clock);
      chk(nm, e, reg_rdata);
   endtask
   task automatic smp(logic [15:0] d);
      sample_en = 1;
      data_in = d;
      @(negedge clock);
      sample_en = 0;
      chk("valid", 1, out_valid);
      @(negedge clock);
      chk("valid", 0, out_valid);
   endtask
   task automatic t_regs;
      wr(`TOSC_OFF_CTRL, 8'hfe);
      rd(`TOSC_OFF_CTRL, 8'h06, "ctrl");
      wr(10'h11c, 8'h5a);
      rd(10'h11c, 8'h00, "unmapped");
      wr(`TOSC_OFF_TW3, 8'h80);
      rd(`TOSC_OFF_TW3, 8'h80, "tw3");
      $display("t_regs done");
   endtask
   // Dither bits set but oscillator off: still a bypass
   task automatic t_bypass;
      smp(16'h1234);
      chk("i", 32'h1234, i_out);
      chk("q", 0, q_out);
      chk("acc", 0, phase_acc);
      $display("t_bypass done");
   endtask
   // Negative word of 0x80000001, start at 90 degrees
   task automatic t_run;
      wr(`TOSC_OFF_TW0, 8'h01);
      wr(`TOSC_OFF_PH_HI, 8'h40);
      wr(`TOSC_OFF_CTRL, 8'h01);
      repeat (3) @(negedge clock);
      chk("acc", 32'h40000000, phase_acc);
      smp(16'h0100);
      chk("acc", 32'hc0000001, phase_acc);
      // At 90 degrees cosine is zero and sine full scale, product floored
      chk("i", 0, i_out);
      chk("q", 32'hffffff00, q_out);
      smp(16'h0100);
      chk("acc", 32'h40000002, phase_acc);
      sync_event = 1;
      @(negedge clock);
      sync_event = 0;
      @(negedge clock);
      chk("acc", 32'h40000000, phase_acc);
      wr(`TOSC_OFF_CTRL, 8'h00);
      chk("acc", 0, phase_acc);
      $display("t_run done");
   endtask
   // Zero input: any nonzero output can only be dither
   task automatic t_dither;
      int hits;
      hits = 0;
      wr(`TOSC_OFF_CTRL, 8'h03);
      chk("acc", 32'h40000000, phase_acc);
      repeat (8)
      begin
         smp(16'h0000);
         if (i_out !== 16'h0000 || q_out !== 16'h0000)
            hits++;
      end
      chk("dither", 1, hits > 0);
      wr(`TOSC_OFF_CTRL, 8'h01);
      repeat (4)
      begin
         smp(16'h0000);
         chk("i", 0, i_out);
         chk("q", 0, q_out);
      end
      $display("t_dither done");
   endtask
   // Reset mid-run: registers clear and the block falls back to bypass
   task automatic t_reset;
      rst_n = 0;
      repeat (2) @(negedge clock);
      rst_n = 1;
      chk("acc", 0, phase_acc);
      rd(`TOSC_OFF_TW3, 8'h00, "tw3");
      rd(`TOSC_OFF_CTRL, 8'h00, "ctrl");
      smp(16'h0055);
      chk("i", 32'h0055, i_out);
      $display("t_reset done");
   endtask
   task automatic end_sim;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Hang guard, far above the tests' length
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 1000)
      begin
         n_fail++;
         end_sim;
      end
   end
   initial
   begin
      repeat (8) @(negedge clock);
      rst_n = 1;
      t_regs;
      t_bypass;
      t_run;
      t_dither;
      t_reset;
      end_sim;
   end
endmodule // tosc_core_tb_top
`default_nettype wire
